// ==== include/boot_seq_defines.vh ====
// Constants for the boot source sequencer: mode codes, addresses, header layout.
// Assumes inclusion by bare name from every file that needs them.
`ifndef BOOT_SEQ_DEFINES_VH
`define BOOT_SEQ_DEFINES_VH

// ----------------
// Mode pin codes
// ----------------
`define M2_SKIP_BOOT_BIT     2'h0
`define M2_FLASH      2'h1
`define M2_SPI_SLAVE  2'h2
`define M2_SPI_MASTER 2'h3
`define M3_SKIP_BOOT_BIT     3'h0
`define M3_FLASH      3'h1
`define M3_RESERVED   3'h2
`define M3_SPI_MASTER 3'h3
`define M3_SPI_SLAVE  3'h4
`define M3_TWI_MEM    3'h5
`define M3_TWI_HOST   3'h6
`define M3_UART       3'h7

// Source select one-hot bit indices
`define SRC_NOB  0
`define SRC_FLS  1
`define SRC_SPIM 2
`define SRC_SPIS 3
`define SRC_TWIM 4
`define SRC_TWIS 5
`define SRC_UART 6
`define SRC_RSV  7

// ----------------
// Addresses, bank timing, configuration register
// ----------------
`define BANK0_BASE  32'h2000_0000
`define L1_BASE     32'hFFA0_0000
`define L1_ALT_BASE 32'hFFA0_8000
`define BANK_HOLD   4'h3
`define BANK_ACCESS 4'hF
`define BANK_SETUP  4'h4
`define CFG_SKIP_BIT 4

// ----------------
// Stream formats
// ----------------
`define FW_8BIT     8'h40
`define FW_16_DMA8  8'h60
`define FW_16_DMA16 8'h20
`define FCFG_NONE   2'h0
`define FCFG_8      2'h1
`define FCFG_16D8   2'h2
`define FCFG_16D16  2'h3
`define SPI_RD_CMD  8'h03
`define SPI_ADDR_BYTE 8'h00
`define SPI_FLOAT   8'hFF
`define SPI_ADDR_MAX 3'h4
`define TWI_MEM_ID  8'hA0
`define TWI_HOST_ID 8'h5F
`define TWI_START   16'h0000
`define ACK_HEAD    8'hBF
`define ACK_TAIL    8'h00
`define ACK_LAST    2'h3
`define HDR_LAST    4'h9
`define FLG_ZERO    0
`define FLG_INIT    3
`define FLG_IGNORE  4
`define FLG_FINAL   15
`define FLG_HW_HI   74
`define FLG_HW_LO   69

`endif

// ==== verilog/boot_source_sequencer.v ====
// Boot source sequencer: samples mode pins, picks a boot source, parses the
// block stream and writes blocks to memory, then hands over a jump address.
// Assumes byte engines for SPI slave, two-wire and UART data sit outside on
// sys_clk; the UART receive pin is raw and synchronised here.
`timescale 1ns/10ps
`include "boot_seq_defines.vh"

// Function
// R1 - Enter boot selected by dedicated mode pins; pins readable in reset config register.
// R2 - Mode 00 skips boot logic and runs from 16-bit bank 0 base.
// R3 - Two-bit codes: 01 flash, 10 SPI slave, 11 SPI master.
// R4 - Three-bit codes map none, flash, reserved, SPI master/slave, two-wire, UART.
// R5 - No-boot and flash use 16-bit packing and slowest bank timing 3/15/4; flash decode clears packing until the first byte sets it.
// R6 - Flash first byte 0x40, 0x60 or 0x20 picks width and DMA size.
// R7 - SPI master: select, read command, zero address bytes until device detected.
// R8 - SPI slave: host wait pin asserted while busy; host then holds bytes.
// R9 - Host wait pin choice taken from flag word bits 10 to 5.
// R10 - UART: measure host '@' character to derive bit rate.
// R11 - Send four-byte acknowledge 0xBF, divisor low, divisor high, 0x00.
// R12 - UART download: clear-to-send deasserted whenever host must wait.
// R13 - Two-wire memory: master, slave 0xA0, sequential reads from address 0x0000.
// R14 - Two-wire host: answer as slave 0x5F, host then downloads.
// R15 - Drop to lowest priority level, unless variant keeps reset priority.
// R16 - Software reset with skip-boot bit set jumps straight to L1 start.
// R17 - Stream is blocks, each behind a 10-byte header.
// R18 - Header: address, count, 2-byte flag; zero-fill blocks have no body.
// R19 - Init block loaded then called; boot resumes after it returns.
// R20 - After final block jump to L1 start at lowest priority.
// R21 - Mode pins captured once after reset release and held all boot.
module boot_source_sequencer (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [2:0]  bootModePins,
  input  wire        threeBitMode,
  input  wire        l1AltBase,
  input  wire        keepResetPrio,
  input  wire        swResetCause,
  input  wire        skipBootBit,
  output wire [15:0] systemResetConfigReg,
  output reg         lowestPrio_r,
  output reg  [3:0]  bankHold_r,
  output reg  [3:0]  bankAccess_r,
  output reg  [3:0]  bankSetup_r,
  output reg         pack16_r,
  output reg  [1:0]  flashCfg_r,
  output reg  [31:0] extRdAddr_r,
  output reg         extRdStb_r,
  input  wire        extRdAck,
  input  wire [7:0]  extRdData,
  output reg         spiBootSelect_r,
  output reg  [7:0]  spiTx_r,
  output reg         spiTxStb_r,
  input  wire        spiRxStb,
  input  wire [7:0]  spiRx,
  output reg  [2:0]  spiAddrBytes_r,
  output reg         twiEnable_r,
  output reg         twiMaster_r,
  output reg  [7:0]  twiSlaveId_r,
  output reg  [15:0] twiMemAddr_r,
  input  wire        uartRxd,
  output reg         uartTxd_r,
  output wire        uartCts,
  output reg  [15:0] baudDivisor_r,
  input  wire [7:0]  srcByte,
  input  wire        srcValid,
  output wire        srcReady,
  output wire        hostWait,
  output reg  [5:0]  hostWaitSel_r,
  output reg  [31:0] memAddr_r,
  output reg  [7:0]  memData_r,
  output reg         memWe_r,
  output reg         initCall_r,
  output reg  [31:0] initAddr_r,
  input  wire        initDone,
  output reg  [31:0] jumpAddr_r,
  output reg         jumpValid_r,
  output reg         bootError_r
);

  // ----------------
  // States
  // ----------------
  localparam [10:0] ST_CAP   = 11'h001;
  localparam [10:0] ST_DEC   = 11'h002;
  localparam [10:0] ST_BAUD  = 11'h004;
  localparam [10:0] ST_ACK   = 11'h008;
  localparam [10:0] ST_CMD   = 11'h010;
  localparam [10:0] ST_PROBE = 11'h020;
  localparam [10:0] ST_HDR   = 11'h040;
  localparam [10:0] ST_BODY  = 11'h080;
  localparam [10:0] ST_FILL  = 11'h100;
  localparam [10:0] ST_INIT  = 11'h200;
  localparam [10:0] ST_DONE  = 11'h400;

  reg  [10:0] state_r;
  reg  [2:0]  modeS1_r;
  reg  [2:0]  modeS2_r;
  reg  [2:0]  modeCap_r;
  reg  [1:0]  capCnt_r;
  reg         rxS1_r;
  reg         rxS2_r;
  reg         rxD_r;
  reg  [7:0]  srcSel_r;
  reg  [7:0]  srcNxt;
  reg         reqPend_r;
  reg         firstByte_r;
  reg  [79:0] hdrSh_r;
  reg  [3:0]  hdrCnt_r;
  reg  [31:0] blkAddr_r;
  reg  [31:0] blkCnt_r;
  reg  [15:0] flags_r;
  reg         initPend_r;
  reg         baudRun_r;
  reg  [19:0] baudCnt_r;
  reg  [16:0] bitCyc_r;
  reg  [16:0] txTick_r;
  reg  [3:0]  txBits_r;
  reg  [8:0]  txSh_r;
  reg  [1:0]  ackIdx_r;
  reg         ackLoaded_r;
  reg  [7:0]  ackByte;

  wire        isHdr    = (state_r == ST_HDR);
  wire        wantByte = isHdr | ((state_r == ST_BODY) & (blkCnt_r != 32'h0));
  wire        genSrc   = srcSel_r[`SRC_SPIS] | srcSel_r[`SRC_TWIM] |
                         srcSel_r[`SRC_TWIS] | srcSel_r[`SRC_UART];
  wire        rspStb   = srcSel_r[`SRC_FLS] ? extRdAck : spiRxStb;
  wire        byteVld  = genSrc ? (srcValid & srcReady) : (reqPend_r & rspStb);
  wire [7:0]  byteIn   = srcSel_r[`SRC_FLS]  ? extRdData :
                         srcSel_r[`SRC_SPIM] ? spiRx : srcByte;
  wire [79:0] hdrNxt   = {byteIn, hdrSh_r[79:8]};
  wire [31:0] l1Base   = l1AltBase ? `L1_ALT_BASE : `L1_BASE;
  wire        rxFall   = rxD_r & ~rxS2_r;
  wire [10:0] postState = flags_r[`FLG_INIT]  ? ST_INIT :
                          flags_r[`FLG_FINAL] ? ST_DONE : ST_HDR;
  // Index of the acknowledge byte that the next frame carries
  wire [1:0]  ackSel   = ackIdx_r + {1'b0, ackLoaded_r};

  // ----------------
  // Status and hold-off
  // ----------------
  assign systemResetConfigReg = {13'h0, modeCap_r} |
                                ({15'h0, skipBootBit} << `CFG_SKIP_BIT);  // [R1]
  assign srcReady = genSrc & wantByte;
  // Low whenever the block cannot take a byte, including before the acknowledge
  assign uartCts  = srcSel_r[`SRC_UART] & srcReady;                      // [R12]
  assign hostWait = srcSel_r[`SRC_SPIS] & ~srcReady;                     // [R8]

  // ----------------
  // Mode decode
  // ----------------
  always @* begin
    srcNxt = 8'h00;
    if (!threeBitMode) begin
      case (modeCap_r[1:0])                                              // [R3]
        `M2_SKIP_BOOT_BIT:     srcNxt[`SRC_NOB]  = 1'b1;
        `M2_FLASH:      srcNxt[`SRC_FLS]  = 1'b1;
        `M2_SPI_SLAVE:  srcNxt[`SRC_SPIS] = 1'b1;
        default:        srcNxt[`SRC_SPIM] = 1'b1;
      endcase
    end else begin
      case (modeCap_r)                                                   // [R4]
        `M3_SKIP_BOOT_BIT:     srcNxt[`SRC_NOB]  = 1'b1;
        `M3_FLASH:      srcNxt[`SRC_FLS]  = 1'b1;
        `M3_RESERVED:   srcNxt[`SRC_RSV]  = 1'b1;
        `M3_SPI_MASTER: srcNxt[`SRC_SPIM] = 1'b1;
        `M3_SPI_SLAVE:  srcNxt[`SRC_SPIS] = 1'b1;
        `M3_TWI_MEM:    srcNxt[`SRC_TWIM] = 1'b1;
        `M3_TWI_HOST:   srcNxt[`SRC_TWIS] = 1'b1;
        default:        srcNxt[`SRC_UART] = 1'b1;
      endcase
    end
  end

  always @* begin
    case (ackSel)                                                        // [R11]
      2'h0:    ackByte = `ACK_HEAD;
      2'h1:    ackByte = baudDivisor_r[7:0];
      2'h2:    ackByte = baudDivisor_r[15:8];
      default: ackByte = `ACK_TAIL;
    endcase
  end

  // ----------------
  // Pin synchronisers
  // ----------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      modeS1_r <= 3'h0;
      modeS2_r <= 3'h0;
      rxS1_r   <= 1'b1;
      rxS2_r   <= 1'b1;
      rxD_r    <= 1'b1;
    end else begin
      modeS1_r <= bootModePins;
      modeS2_r <= modeS1_r;
      rxS1_r   <= uartRxd;
      rxS2_r   <= rxS1_r;
      rxD_r    <= rxS2_r;
    end
  end

  // ----------------
  // Sequencer
  // ----------------
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_CAP;        modeCap_r <= 3'h0;      capCnt_r <= 2'h0;
      srcSel_r <= 8'h00;        reqPend_r <= 1'b0;      firstByte_r <= 1'b0;
      hdrSh_r <= 80'h0;         hdrCnt_r <= 4'h0;       blkAddr_r <= 32'h0;
      blkCnt_r <= 32'h0;        flags_r <= 16'h0;       initPend_r <= 1'b0;
      baudRun_r <= 1'b0;        baudCnt_r <= 20'h0;     bitCyc_r <= 17'h0;
      txTick_r <= 17'h0;        txBits_r <= 4'h0;       txSh_r <= 9'h1FF;
      ackIdx_r <= 2'h0;         ackLoaded_r <= 1'b0;    lowestPrio_r <= 1'b0;
      bankHold_r <= 4'h0;       bankAccess_r <= 4'h0;   bankSetup_r <= 4'h0;
      pack16_r <= 1'b0;         flashCfg_r <= `FCFG_NONE;
      extRdAddr_r <= 32'h0;     extRdStb_r <= 1'b0;     spiBootSelect_r <= 1'b0;
      spiTx_r <= 8'h00;         spiTxStb_r <= 1'b0;     spiAddrBytes_r <= 3'h0;
      twiEnable_r <= 1'b0;      twiMaster_r <= 1'b0;    twiSlaveId_r <= 8'h00;
      twiMemAddr_r <= 16'h0;    uartTxd_r <= 1'b1;      baudDivisor_r <= 16'h0;
      hostWaitSel_r <= 6'h0;    memAddr_r <= 32'h0;     memData_r <= 8'h00;
      memWe_r <= 1'b0;          initCall_r <= 1'b0;     initAddr_r <= 32'h0;
      jumpAddr_r <= 32'h0;      jumpValid_r <= 1'b0;    bootError_r <= 1'b0;
    end else begin
      memWe_r    <= 1'b0;
      initCall_r <= 1'b0;
      extRdStb_r <= 1'b0;
      spiTxStb_r <= 1'b0;
      // Byte fetches for sources that this block itself paces
      if (wantByte && !reqPend_r && (srcSel_r[`SRC_FLS] | srcSel_r[`SRC_SPIM])) begin
        reqPend_r  <= 1'b1;
        extRdStb_r <= srcSel_r[`SRC_FLS];
        spiTxStb_r <= srcSel_r[`SRC_SPIM];
        spiTx_r    <= `SPI_ADDR_BYTE;
      end
      if (byteVld && !genSrc && wantByte) begin
        reqPend_r   <= 1'b0;
        extRdAddr_r <= extRdAddr_r + 32'h1;
      end
      case (state_r)
        ST_CAP: begin
          // Wait for the pin synchroniser to fill, then freeze the code
          capCnt_r <= capCnt_r + 2'h1;
          if (capCnt_r == 2'h3) begin
            modeCap_r <= modeS2_r;                                       // [R21]
            state_r   <= ST_DEC;
          end
        end
        ST_DEC: begin
          srcSel_r <= srcNxt;                                            // [R1]
          if (!srcNxt[`SRC_NOB])
            lowestPrio_r <= ~keepResetPrio;                              // [R15]
          jumpAddr_r <= l1Base;
          if (srcNxt[`SRC_NOB] | srcNxt[`SRC_FLS]) begin
            bankHold_r   <= `BANK_HOLD;                                  // [R5]
            bankAccess_r <= `BANK_ACCESS;
            bankSetup_r  <= `BANK_SETUP;
            pack16_r     <= srcNxt[`SRC_NOB];
          end
          if (swResetCause && skipBootBit && !srcNxt[`SRC_NOB]) begin
            state_r <= ST_DONE;                                          // [R16]
          end else if (srcNxt[`SRC_NOB]) begin
            jumpAddr_r <= `BANK0_BASE;                                   // [R2]
            state_r    <= ST_DONE;
          end else if (srcNxt[`SRC_RSV]) begin
            bootError_r <= 1'b1;
            state_r     <= ST_DONE;
          end else if (srcNxt[`SRC_SPIM]) begin
            spiBootSelect_r <= 1'b1;                                     // [R7]
            state_r         <= ST_CMD;
          end else if (srcNxt[`SRC_UART]) begin
            state_r <= ST_BAUD;
          end else begin
            extRdAddr_r  <= `BANK0_BASE;
            firstByte_r  <= srcNxt[`SRC_FLS];
            twiEnable_r  <= srcNxt[`SRC_TWIM] | srcNxt[`SRC_TWIS];
            twiMaster_r  <= srcNxt[`SRC_TWIM];                           // [R13]
            twiSlaveId_r <= srcNxt[`SRC_TWIM] ? `TWI_MEM_ID : `TWI_HOST_ID; // [R14]
            twiMemAddr_r <= `TWI_START;
            state_r      <= ST_HDR;
          end
        end
        ST_BAUD: begin
          // '@' holds the line low for seven bit times; the next falling edge
          // lands eight bit times after the start edge
          if (!baudRun_r) begin
            if (rxFall) begin
              baudRun_r <= 1'b1;
              baudCnt_r <= 20'h1;
            end
          end else if (rxFall) begin
            baudDivisor_r <= {3'h0, baudCnt_r[19:7]};                    // [R10]
            bitCyc_r      <= baudCnt_r[19:3];
            ackIdx_r      <= 2'h0;
            state_r       <= ST_ACK;
          end else begin
            baudCnt_r <= baudCnt_r + 20'h1;
          end
        end
        ST_ACK: begin
          if (txBits_r == 4'h0) begin
            if (ackLoaded_r && ackIdx_r == `ACK_LAST) begin
              state_r <= ST_HDR;                                         // [R11]
            end else begin
              ackIdx_r    <= ackSel;
              ackLoaded_r <= 1'b1;
              uartTxd_r   <= 1'b0;
              txSh_r      <= {1'b1, ackByte};
              txBits_r    <= 4'hA;
              txTick_r    <= bitCyc_r;
            end
          end else if (txTick_r <= 17'h1) begin
            txTick_r  <= bitCyc_r;
            txBits_r  <= txBits_r - 4'h1;
            uartTxd_r <= txSh_r[0];
            txSh_r    <= {1'b1, txSh_r[8:1]};
          end else begin
            txTick_r <= txTick_r - 17'h1;
          end
        end
        ST_CMD: begin
          if (!reqPend_r) begin
            spiTx_r    <= `SPI_RD_CMD;                                   // [R7]
            spiTxStb_r <= 1'b1;
            reqPend_r  <= 1'b1;
          end else if (spiRxStb) begin
            reqPend_r      <= 1'b0;
            spiAddrBytes_r <= 3'h0;
            state_r        <= ST_PROBE;
          end
        end
        ST_PROBE: begin
          if (!reqPend_r) begin
            spiTx_r    <= `SPI_ADDR_BYTE;
            spiTxStb_r <= 1'b1;
            reqPend_r  <= 1'b1;
          end else if (spiRxStb) begin
            reqPend_r <= 1'b0;
            // A driven byte after the address proves the address width
            if (spiRx != `SPI_FLOAT && spiAddrBytes_r != 3'h0) begin
              hdrSh_r  <= {spiRx, hdrSh_r[79:8]};                        // [R7]
              hdrCnt_r <= 4'h1;
              state_r  <= ST_HDR;
            end else begin
              spiAddrBytes_r <= spiAddrBytes_r + 3'h1;
              if (spiAddrBytes_r + 3'h1 == `SPI_ADDR_MAX)
                state_r <= ST_HDR;
            end
          end
        end
        ST_HDR: begin
          if (byteVld) begin
            hdrSh_r     <= hdrNxt;                                       // [R17]
            firstByte_r <= 1'b0;
            if (firstByte_r) begin
              pack16_r <= (byteIn != `FW_8BIT);                          // [R6]
              case (byteIn)
                `FW_8BIT:     flashCfg_r <= `FCFG_8;
                `FW_16_DMA8:  flashCfg_r <= `FCFG_16D8;
                `FW_16_DMA16: flashCfg_r <= `FCFG_16D16;
                default:      flashCfg_r <= `FCFG_NONE;
              endcase
            end
            if (hdrCnt_r == `HDR_LAST) begin
              hdrCnt_r   <= 4'h0;
              blkAddr_r  <= hdrNxt[31:0];                                // [R18]
              initAddr_r <= hdrNxt[31:0];
              blkCnt_r   <= hdrNxt[63:32];
              flags_r    <= hdrNxt[79:64];
              if (srcSel_r[`SRC_SPIS])
                hostWaitSel_r <= hdrNxt[`FLG_HW_HI:`FLG_HW_LO];          // [R9]
              state_r <= hdrNxt[64 + `FLG_ZERO] ? ST_FILL : ST_BODY;     // [R18]
            end else begin
              hdrCnt_r <= hdrCnt_r + 4'h1;
            end
          end
        end
        ST_BODY: begin
          if (blkCnt_r == 32'h0) begin
            state_r <= postState;
          end else if (byteVld) begin
            memWe_r   <= ~flags_r[`FLG_IGNORE];
            memAddr_r <= blkAddr_r;
            memData_r <= byteIn;
            blkAddr_r <= blkAddr_r + 32'h1;
            blkCnt_r  <= blkCnt_r - 32'h1;
          end
        end
        ST_FILL: begin
          if (blkCnt_r == 32'h0) begin
            state_r <= postState;
          end else begin
            memWe_r   <= 1'b1;                                           // [R18]
            memAddr_r <= blkAddr_r;
            memData_r <= 8'h00;
            blkAddr_r <= blkAddr_r + 32'h1;
            blkCnt_r  <= blkCnt_r - 32'h1;
          end
        end
        ST_INIT: begin
          if (!initPend_r) begin
            initCall_r <= 1'b1;                                          // [R19]
            initPend_r <= 1'b1;
          end else if (initDone) begin
            initPend_r <= 1'b0;
            state_r    <= flags_r[`FLG_FINAL] ? ST_DONE : ST_HDR;        // [R19]
          end
        end
        ST_DONE: begin
          jumpValid_r     <= ~bootError_r;                               // [R20]
          spiBootSelect_r <= 1'b0;
        end
        default: state_r <= ST_CAP;
      endcase
    end
  end

endmodule // boot_source_sequencer

// ==== sim/boot_seq_monitor.sv ====
// Checker for the boot source sequencer: decision, jump and select relations.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/10ps
module boot_seq_monitor (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        l1AltBase,
  input wire        keepResetPrio,
  input wire        swResetCause,
  input wire        skipBootBit,
  input wire [15:0] systemResetConfigReg,
  input wire        lowestPrio_r,
  input wire [3:0]  bankHold_r,
  input wire [3:0]  bankAccess_r,
  input wire [3:0]  bankSetup_r,
  input wire        pack16_r,
  input wire        spiBootSelect_r,
  input wire [7:0]  spiTx_r,
  input wire        spiTxStb_r,
  input wire [31:0] jumpAddr_r,
  input wire        jumpValid_r,
  input wire        bootError_r
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire [2:0] code = systemResetConfigReg[2:0];
  sequence s_jump;
    $rose(jumpValid_r);
  endsequence
  sequence s_quiet;
    (!jumpValid_r)[*3];
  endsequence
  property p_cfg_skip;
    systemResetConfigReg[4] == skipBootBit;
  endproperty
  a_cfg_skip: assert property (p_cfg_skip) else $error("skip bit not mirrored");
  property p_hold_code;
    jumpValid_r && $past(jumpValid_r) |-> $stable(code);
  endproperty
  a_hold_code: assert property (p_hold_code) else $error("mode code moved");
  property p_skip_boot_bit_addr;
    s_jump ##0 (code == 3'h0) |-> jumpAddr_r == 32'h2000_0000;
  endproperty
  a_skip_boot_bit_addr: assert property (p_skip_boot_bit_addr) else $error("bad no-boot start");
  property p_bank;
    jumpValid_r && code == 3'h0 |-> bankHold_r == 4'h3 && bankAccess_r == 4'hF
      && bankSetup_r == 4'h4 && pack16_r;
  endproperty
  a_bank: assert property (p_bank) else $error("bank timing wrong");
  property p_l1;
    s_jump ##0 (code != 3'h0) |-> jumpAddr_r == (l1AltBase ? 32'hFFA0_8000 : 32'hFFA0_0000);
  endproperty
  a_l1: assert property (p_l1) else $error("bad L1 jump");
  property p_prio;
    s_jump ##0 (code != 3'h0 && !swResetCause && !keepResetPrio) |-> lowestPrio_r;
  endproperty
  a_prio: assert property (p_prio) else $error("priority not lowered");
  property p_err;
    $rose(bootError_r) |-> code == 3'h2 ##1 s_quiet;
  endproperty
  a_err: assert property (p_err) else $error("reserved mode jumped");
  property p_spi;
    spiTxStb_r |-> spiBootSelect_r && (spiTx_r == 8'h03 || spiTx_r == 8'h00);
  endproperty
  a_spi: assert property (p_spi) else $error("bad serial memory byte");
endmodule // boot_seq_monitor
bind boot_source_sequencer boot_seq_monitor u_boot_seq_monitor (.*);

// ==== sim/boot_mem_model.sv ====
// Boot memory model: parallel flash and serial memory holding one final block.
// Assumes one outstanding request at a time on either path.
`timescale 1ns/10ps
module boot_mem_model (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire       extRdStb,
  output reg        extRdAck,
  output reg  [7:0] extRdData,
  input  wire       spiTxStb,
  output reg        spiRxStb,
  output reg  [7:0] spiRx
);
  // Header at FF800040, two bytes, final flag, body AA 55
  localparam [95:0] IMG = 96'h55AA_8000_0000_0002_FF80_0040;
  reg [3:0] idx;
  reg [1:0] dly;
  reg       isSpi;
  reg [1:0] floatCnt;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {idx, dly, isSpi, floatCnt, extRdAck, spiRxStb} <= 11'h000;
      extRdData <= 8'h00;
      spiRx <= 8'h00;
    end else begin
      extRdAck <= 1'b0;
      spiRxStb <= 1'b0;
      // Idle lines toggle so stale data never looks valid
      extRdData <= ~extRdData;
      spiRx <= ~spiRx;
      if (extRdStb || spiTxStb) begin
        dly <= idx[0] ? 2'h3 : 2'h1;
        isSpi <= spiTxStb;
      end else if (dly == 2'h1) begin
        dly <= 2'h0;
        if (isSpi) begin
          spiRxStb <= 1'b1;
          // Bus floats during the command and one address byte
          spiRx <= (floatCnt == 2'h2) ? IMG[{idx, 3'h0} +: 8] : 8'hFF;
          floatCnt <= (floatCnt == 2'h2) ? floatCnt : floatCnt + 2'h1;
          idx <= (floatCnt == 2'h2) ? idx + 4'h1 : idx;
        end else begin
          extRdAck <= 1'b1;
          extRdData <= IMG[{idx, 3'h0} +: 8];
          idx <= idx + 4'h1;
        end
      end else if (dly != 2'h0) dly <= dly - 2'h1;
    end
  end
endmodule // boot_mem_model

// ==== sim/boot_source_sequencer_test.sv ====
// Testbench for the boot source sequencer: mode decode, flash and serial boot, UART bit-rate acknowledge.
// Assumes the memory model answers reads and the checker is bound.
`timescale 1ns/10ps
module boot_source_sequencer_test;
  reg         sys_clk, rst_n, threeBitMode, l1AltBase, swResetCause, skipBootBit, uartRxd;
  reg  [2:0]  bootModePins;
  wire        lowestPrio_r, pack16_r, extRdStb_r, extRdAck, spiTxStb_r, spiRxStb;
  wire        twiMaster_r, uartTxd_r, memWe_r, jumpValid_r, bootError_r;
  wire [1:0]  flashCfg_r;
  wire [2:0]  spiAddrBytes_r;
  wire [3:0]  bankHold_r, bankAccess_r, bankSetup_r;
  wire [7:0]  extRdData, spiRx, twiSlaveId_r, memData_r;
  wire [15:0] systemResetConfigReg, twiMemAddr_r, baudDivisor_r;
  wire [31:0] memAddr_r, jumpAddr_r;
  integer     miscompares, n_checks;
  boot_source_sequencer u_boot_source_sequencer (.sys_clk(sys_clk), .rst_n(rst_n),
    .bootModePins(bootModePins), .threeBitMode(threeBitMode), .l1AltBase(l1AltBase),
    .keepResetPrio(1'b0), .swResetCause(swResetCause), .skipBootBit(skipBootBit),
    .systemResetConfigReg(systemResetConfigReg), .lowestPrio_r(lowestPrio_r),
    .bankHold_r(bankHold_r), .bankAccess_r(bankAccess_r), .bankSetup_r(bankSetup_r),
    .pack16_r(pack16_r), .flashCfg_r(flashCfg_r), .extRdAddr_r(), .extRdStb_r(extRdStb_r),
    .extRdAck(extRdAck), .extRdData(extRdData), .spiBootSelect_r(), .spiTx_r(),
    .spiTxStb_r(spiTxStb_r), .spiRxStb(spiRxStb), .spiRx(spiRx),
    .spiAddrBytes_r(spiAddrBytes_r), .twiEnable_r(), .twiMaster_r(twiMaster_r),
    .twiSlaveId_r(twiSlaveId_r), .twiMemAddr_r(twiMemAddr_r), .uartRxd(uartRxd),
    .uartTxd_r(uartTxd_r), .uartCts(), .baudDivisor_r(baudDivisor_r), .srcByte(8'h00),
    .srcValid(1'b0), .srcReady(), .hostWait(), .hostWaitSel_r(), .memAddr_r(memAddr_r),
    .memData_r(memData_r), .memWe_r(memWe_r), .initCall_r(), .initAddr_r(),
    .initDone(1'b0), .jumpAddr_r(jumpAddr_r), .jumpValid_r(jumpValid_r),
    .bootError_r(bootError_r));
  boot_mem_model u_boot_mem_model (.sys_clk(sys_clk), .rst_n(rst_n), .extRdStb(extRdStb_r),
    .extRdAck(extRdAck), .extRdData(extRdData), .spiTxStb(spiTxStb_r),
    .spiRxStb(spiRxStb), .spiRx(spiRx));
  task check(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task boot(input [2:0] m, input t, input a, input s, input k);
    begin
      @(posedge sys_clk);
      #1;
      {rst_n, bootModePins, threeBitMode, l1AltBase, swResetCause, skipBootBit} = {1'b0, m, t, a, s, k};
      repeat (5) @(posedge sys_clk);
      #1 rst_n = 1'b1;
    end
  endtask
  task wait_done;
    integer i;
    begin
      for (i = 0; i < 400 && jumpValid_r !== 1'b1 && bootError_r !== 1'b1; i = i + 1)
        @(posedge sys_clk);
      #1;
    end
  endtask
  task sc_decode;
    begin
      boot(3'h0, 1'b0, 1'b0, 1'b0, 1'b0);
      wait_done;
      check(jumpAddr_r, 32'h2000_0000);
      check({bankHold_r, bankAccess_r, bankSetup_r, pack16_r}, 13'h07E9);
      bootModePins = 3'h5;
      repeat (4) @(posedge sys_clk);
      check(systemResetConfigReg, 16'h0000);
      boot(3'h2, 1'b1, 1'b0, 1'b0, 1'b0);
      wait_done;
      check({bootError_r, jumpValid_r}, 2'h2);
      boot(3'h1, 1'b1, 1'b1, 1'b1, 1'b1);
      wait_done;
      check(jumpAddr_r, 32'hFFA0_8000);
      check(systemResetConfigReg, 16'h0011);
      boot(3'h5, 1'b1, 1'b0, 1'b0, 1'b0);
      repeat (8) @(posedge sys_clk);
      check({twiMaster_r, twiSlaveId_r, twiMemAddr_r}, 25'h1A0_0000);
      boot(3'h6, 1'b1, 1'b0, 1'b0, 1'b0);
      repeat (8) @(posedge sys_clk);
      check({twiMaster_r, twiSlaveId_r}, 9'h05F);
    end
  endtask
  task sc_stream(input [2:0] m, input t);
    integer i, k;
    begin
      boot(m, t, 1'b0, 1'b0, 1'b0);
      k = 0;
      for (i = 0; i < 600 && jumpValid_r !== 1'b1; i = i + 1) begin
        @(posedge sys_clk);
        #1;
        if (memWe_r === 1'b1) begin
          check(memAddr_r, 32'hFF80_0040 + k);
          check(memData_r, k ? 8'h55 : 8'hAA);
          k = k + 1;
        end
      end
      check(jumpValid_r, 1'b1);
      if (jumpValid_r !== 1'b1) close_out;
      check(k, 2);
      check({jumpAddr_r, lowestPrio_r}, 33'h1_FF40_0001);
      if (m == 3'h1) check({flashCfg_r, bankAccess_r}, 6'h1F);
      else check(spiAddrBytes_r, 3'h1);
    end
  endtask
  task sc_uart;
    integer i, j, b;
    reg [9:0] f;
    reg [31:0] rx;
    begin
      boot(3'h7, 1'b1, 1'b0, 1'b0, 1'b0);
      repeat (8) @(posedge sys_clk);
      #37;
      f = {1'b1, 8'h40, 1'b0};
      fork
        for (i = 0; i < 10; i = i + 1) begin
          uartRxd = f[i];
          #160;
        end
        for (b = 0; b < 4; b = b + 1) begin
          for (j = 0; j < 400 && uartTxd_r !== 1'b1; j = j + 1) @(posedge sys_clk);
          for (j = 0; j < 2000 && uartTxd_r !== 1'b0; j = j + 1) @(posedge sys_clk);
          repeat (10) @(posedge sys_clk);
          for (j = 0; j < 8; j = j + 1) begin
            repeat (20) @(posedge sys_clk);
            rx = {uartTxd_r, rx[31:1]};
          end
        end
      join
      check(rx, 32'h0000_01BF);
      check(baudDivisor_r, 16'h0001);
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_n, threeBitMode, l1AltBase, swResetCause, skipBootBit, bootModePins} = 8'h00;
    uartRxd = 1'b1;
    miscompares = 0;
    n_checks = 0;
    sc_decode;
    sc_stream(3'h1, 1'b1);
    sc_stream(3'h3, 1'b0);
    sc_uart;
    close_out;
  end
endmodule // boot_source_sequencer_test
